// ---- rtl/ext_event_consts.vh ----
// Register offsets, field positions and reset values of the event and encoder input block.
`ifndef EXT_EVENT_CONSTS_VH
`define EXT_EVENT_CONSTS_VH

// ***************************************************************
// Register byte offsets (low address byte).
// ***************************************************************
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_EVENTS    8'h08
`define OFS_WIN_LO    8'h0C
`define OFS_WIN_HI    8'h10
`define OFS_SHIFT0    8'h20
`define OFS_POS0      8'h40

// ***************************************************************
// Field positions.
// ***************************************************************
`define CTRL_FOLLOW   0
`define CTRL_MOTOR_CLR 1
`define CTRL_IDX_ZERO 2
`define STAT_RUN      0
`define STAT_MOTOR    1
`define STAT_CFG_LO   2
`define STAT_LASER    4
`define STAT_GPIO_LO  8
`define STAT_FAULT_LO 16

// ***************************************************************
// GPIO input numbers and reset values.
// ***************************************************************
`define IN_START      0
`define IN_STOP       1
`define IN_TRIG       2
`define IN_MOTOR      3
`define IN_CFG_LO     4
`define CTRL_RST      32'h0000_0000
`define SHIFT_RST     32'h0000_0001
`define WIN_LO_RST    32'h0000_0000
`define WIN_HI_RST    32'h7FFF_FFFF
`define SETTLE_CYCLES 2'h3

`endif

// ---- rtl/quad_axis.v ----
// One axis: differential encoder receiver, quadrature decoder and position accumulator.
`default_nettype none

module quad_axis #(
  parameter W = 32                         // Position and shift width.
) (
  input  wire         clk_sys,             // System clock.
  input  wire         rst_n,               // Synchronous reset, active low.
  input  wire [5:0]   enc_line,            // {idx_n, idx_p, b_n, b_p, a_n, a_p}.
  input  wire         follow_en,           // Encoder following active.
  input  wire         idx_zero,            // Clear position on index edge.
  input  wire [W-1:0] shift_val,           // Travel per encoder step.
  input  wire         pos_load,            // Load position, one-cycle pulse.
  input  wire [W-1:0] pos_wdata,           // Value to load.
  output reg  [W-1:0] position,            // Tracked position.
  output reg          line_fault           // Some pair shows equal levels.
);

  reg  [5:0] sync1;
  reg  [5:0] sync2;
  reg  [2:0] phase;
  reg  [2:0] phase_d;
  reg        armed;
  wire [2:0] pair_ok;
  wire [2:0] next_phase;
  wire       step;
  wire       up;

  // ***************************************************************
  // Line synchronisers.
  // ***************************************************************
  // Two flops per line; only the second stage is looked at.
  // Reset to the idle pattern (true low, complement high) so no pair looks
  // broken while the stages fill after reset.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1 <= 6'h2A;
      sync2 <= 6'h2A;
    end else begin
      sync1 <= enc_line;
      sync2 <= sync1;
    end
  end

  // A pair is trusted only while true and complement disagree; otherwise
  // the last good level is held so noise on a broken wire cannot count.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pair
      assign pair_ok[g]    = sync2[2*g] ^ sync2[2*g+1];
      assign next_phase[g] = pair_ok[g] ? sync2[2*g] : phase[g];
    end
  endgenerate

  // ***************************************************************
  // Quadrature decoder, four counts per cycle.
  // ***************************************************************
  // A step is one phase change; a double change is a missed state and ignored.
  assign step = (phase[0] ^ phase_d[0]) ^ (phase[1] ^ phase_d[1]);
  assign up   = phase[0] ^ phase_d[1];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      phase      <= 3'h0;
      phase_d    <= 3'h0;
      armed      <= 1'b0;
      line_fault <= 1'b0;
      position   <= {W{1'b0}};
    end else begin
      phase      <= next_phase;
      phase_d    <= phase;
      armed      <= 1'b1;
      line_fault <= ~&pair_ok;
      // Software load wins over counting in the same cycle.
      if (pos_load) begin
        position <= pos_wdata;
      end else if (armed && follow_en && idx_zero && phase[2] && !phase_d[2]) begin
        position <= {W{1'b0}};
      end else if (armed && follow_en && step) begin
        position <= up ? position + shift_val : position - shift_val;
      end
    end
  end

endmodule

`default_nettype wire

// ---- rtl/ext_event_inputs.v ----
// Eight event inputs, three encoder axes and an AHB-Lite register slave.
// Notes on behaviour
// - There are eight general inputs, numbered 0 to 7, that raise events.
// - Only a rising edge on input 0 starts the run; levels and falls do not.
// - A rising edge on input 1 stops the run in progress.
// - A rising edge on input 2 is passed on as the external trigger event.
// - A rising edge on input 3 switches the mirror motor on.
// - Rising edges on inputs 4 to 7 select configuration 1 to 4 as active.
// - Up to three axes, eighteen lines in all, are tracked independently.
// - During a run, the tracked position of axis 0 decides in real time whether the laser is on.
// - Each encoder step moves the axis position by its programmed shift value.
// - With following on, steps come from A/B quadrature and the index is used too.
`default_nettype none
`include "ext_event_consts.vh"

module ext_event_inputs #(
  parameter NAX = 3                        // Number of encoder axes.
) (
  input  wire           clk_sys,           // System clock, 100 MHz.
  input  wire           rst_n,             // Synchronous reset, active low.
  input  wire [7:0]     gpio_in,           // General event inputs.
  input  wire [6*NAX-1:0] enc_line,        // Six differential lines per axis.
  input  wire           hsel,              // AHB-Lite select.
  input  wire [31:0]    haddr,             // AHB-Lite address.
  input  wire [1:0]     htrans,            // AHB-Lite transfer type.
  input  wire           hwrite,            // AHB-Lite write.
  input  wire [2:0]     hsize,             // AHB-Lite size.
  input  wire [31:0]    hwdata,            // AHB-Lite write data.
  input  wire           hready,            // AHB-Lite bus ready.
  output wire           hreadyout,         // Always ready.
  output wire           hresp,             // Always OKAY.
  output reg  [31:0]    hrdata,            // Read data.
  output reg            run_active,        // Processing run in progress.
  output reg            trigger_evt,       // External trigger, one-cycle pulse.
  output reg            motor_en,          // Mirror motor enable.
  output reg  [1:0]     cfg_sel,           // Active configuration minus one.
  output reg            laser_on           // Laser gate from tracked position.
);

  reg  [7:0]     gpio_s1;
  reg  [7:0]     gpio_s2;
  reg  [7:0]     gpio_d;
  reg  [1:0]     settle;
  reg  [7:0]     events;
  reg  [31:0]    ctrl;
  reg  [31:0]    win_lo;
  reg  [31:0]    win_hi;
  reg  [31:0]    shift_val [0:NAX-1];
  reg            dp_write;
  reg  [7:0]     dp_addr;
  reg  [31:0]    next_rdata;
  wire [7:0]     rise;
  wire           acc_ok;
  wire           wr_en;
  wire [32*NAX-1:0] pos_flat;
  wire [NAX-1:0] fault;
  integer        i;
  integer        j;

  // ***************************************************************
  // General input synchroniser and edge detector.
  // ***************************************************************
  // Two flops then a delay flop; the first stage feeds nothing else.
  // Edges are held off for a few cycles after reset so a pin already high
  // at power-up is not mistaken for a rising edge.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      gpio_s1 <= 8'h00;
      gpio_s2 <= 8'h00;
      gpio_d  <= 8'h00;
      settle  <= 2'h0;
    end else begin
      gpio_s1 <= gpio_in;
      gpio_s2 <= gpio_s1;
      gpio_d  <= gpio_s2;
      if (settle != `SETTLE_CYCLES) begin
        settle <= settle + 2'h1;
      end
    end
  end

  assign rise = (settle == `SETTLE_CYCLES) ? (gpio_s2 & ~gpio_d) : 8'h00;

  // ***************************************************************
  // Process events.
  // ***************************************************************
  // Stop beats start when both rise together: the safe outcome wins.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      run_active  <= 1'b0;
      trigger_evt <= 1'b0;
      motor_en    <= 1'b0;
      cfg_sel     <= 2'h0;
    end else begin
      if (rise[`IN_STOP]) begin
        run_active <= 1'b0;
      end else if (rise[`IN_START]) begin
        run_active <= 1'b1;
      end
      trigger_evt <= rise[`IN_TRIG];
      if (rise[`IN_MOTOR]) begin
        motor_en <= 1'b1;
      end else if (wr_en && dp_addr == `OFS_CTRL && hwdata[`CTRL_MOTOR_CLR]) begin
        motor_en <= 1'b0;
      end
      // Lowest input wins if several selects rise in one cycle.
      if (rise[`IN_CFG_LO]) begin
        cfg_sel <= 2'h0;
      end else if (rise[`IN_CFG_LO+1]) begin
        cfg_sel <= 2'h1;
      end else if (rise[`IN_CFG_LO+2]) begin
        cfg_sel <= 2'h2;
      end else if (rise[`IN_CFG_LO+3]) begin
        cfg_sel <= 2'h3;
      end
    end
  end

  // ***************************************************************
  // Encoder axes.
  // ***************************************************************
  // Each axis has its own receiver, decoder and accumulator.
  genvar g;
  generate
    for (g = 0; g < NAX; g = g + 1) begin : g_axis
      quad_axis #(
        .W         (32)
      ) u_axis (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .enc_line  (enc_line[6*g+5:6*g]),
        .follow_en (ctrl[`CTRL_FOLLOW]),
        .idx_zero  (ctrl[`CTRL_IDX_ZERO]),
        .shift_val (shift_val[g]),
        .pos_load  (wr_en && dp_addr == `OFS_POS0 + 8'd4 * g[7:0]),
        .pos_wdata (hwdata),
        .position  (pos_flat[32*g+31:32*g]),
        .line_fault(fault[g])
      );
    end
  endgenerate

  // Laser is gated by the run and by axis 0 lying inside the programmed
  // window; signed compare so travel either side of zero works.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      laser_on <= 1'b0;
    end else begin
      laser_on <= run_active && ($signed(pos_flat[31:0]) >= $signed(win_lo))
                             && ($signed(pos_flat[31:0]) <= $signed(win_hi));
    end
  end

  // ***************************************************************
  // AHB-Lite slave, zero wait states.
  // ***************************************************************
  // Only word accesses are taken; others complete as OKAY with no effect.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc_ok    = hsel && htrans[1] && hready && (hsize == 3'b010);
  assign wr_en     = dp_write;

  // Read data is chosen in the address phase and stands in the data phase.
  always @* begin
    next_rdata = 32'h0000_0000;
    j          = 0;
    case (haddr[7:0])
      `OFS_CTRL:   next_rdata = ctrl;
      `OFS_STATUS: begin
        next_rdata[`STAT_RUN]   = run_active;
        next_rdata[`STAT_MOTOR] = motor_en;
        next_rdata[`STAT_CFG_LO+1:`STAT_CFG_LO] = cfg_sel;
        next_rdata[`STAT_LASER] = laser_on;
        next_rdata[`STAT_GPIO_LO+7:`STAT_GPIO_LO] = gpio_s2;
        next_rdata[`STAT_FAULT_LO+NAX-1:`STAT_FAULT_LO] = fault;
      end
      `OFS_EVENTS: next_rdata[7:0] = events;
      `OFS_WIN_LO: next_rdata = win_lo;
      `OFS_WIN_HI: next_rdata = win_hi;
      default: begin
        for (j = 0; j < NAX; j = j + 1) begin
          if (haddr[7:0] == `OFS_SHIFT0 + 8'd4 * j[7:0]) begin
            next_rdata = shift_val[j];
          end
          if (haddr[7:0] == `OFS_POS0 + 8'd4 * j[7:0]) begin
            next_rdata = pos_flat[32*j +: 32];
          end
        end
      end
    endcase
  end

  // Address phase capture and register writes in the data phase.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      hrdata   <= 32'h0000_0000;
      ctrl     <= `CTRL_RST;
      win_lo   <= `WIN_LO_RST;
      win_hi   <= `WIN_HI_RST;
      events   <= 8'h00;
      for (i = 0; i < NAX; i = i + 1) begin
        shift_val[i] <= `SHIFT_RST;
      end
    end else begin
      dp_write <= acc_ok && hwrite;
      dp_addr  <= haddr[7:0];
      if (acc_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
      // Sticky edge flags: a new edge wins over a write-one clear.
      if (wr_en && dp_addr == `OFS_EVENTS) begin
        events <= (events & ~hwdata[7:0]) | rise;
      end else begin
        events <= events | rise;
      end
      if (wr_en && dp_addr == `OFS_CTRL) begin
        ctrl <= {29'h0000_0000, hwdata[2:0]} & 32'h0000_0005;
      end
      if (wr_en && dp_addr == `OFS_WIN_LO) begin
        win_lo <= hwdata;
      end
      if (wr_en && dp_addr == `OFS_WIN_HI) begin
        win_hi <= hwdata;
      end
      for (i = 0; i < NAX; i = i + 1) begin
        if (wr_en && dp_addr == `OFS_SHIFT0 + 8'd4 * i[7:0]) begin
          shift_val[i] <= hwdata;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- test/enc_model.sv ----
// Far-side encoder model: three axes of differential A, B and index lines.
`default_nettype none

module enc_model (
  input  wire logic [2:0]  pa,       // A phase level per axis.
  input  wire logic [2:0]  pb,       // B phase level per axis.
  input  wire logic [2:0]  pz,       // Index level per axis.
  input  wire logic        fault,    // Shorts the A pair of axis 2.
  output var  logic [17:0] enc_line  // Lines to the block.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Line drivers
  // ****************************************
  // Each axis drives true and inverted lines; a fault makes one pair equal on purpose.
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      enc_line[6*g +: 6] = {~pz[g], pz[g], ~pb[g], pb[g], ~pa[g], pa[g]};
    end
    if (fault) begin
      enc_line[13] = pa[2];
    end
  end
endmodule

`default_nettype wire

// ---- test/event_inputs_monitor.sv ----
// Checker of event and bus timing at the ports of the input block.
`default_nettype none

module event_inputs_monitor (
  input wire logic       clk_sys,     // System clock.
  input wire logic       rst_n,       // Reset, active low.
  input wire logic [7:0] gpio_in,     // Event inputs.
  input wire logic       hreadyout,   // Bus ready.
  input wire logic       hresp,       // Bus response.
  input wire logic       run_active,  // Run state.
  input wire logic       trigger_evt, // Trigger pulse.
  input wire logic       motor_en,    // Motor enable.
  input wire logic [1:0] cfg_sel,     // Active configuration.
  input wire logic       laser_on     // Laser gate.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Assertions
  // ****************************************
  // A pin first sampled high at one edge moves the outputs two edges later, and
  // the checker samples the new value one edge after that, so three sampled edges.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  bus_ready_a: assert property (hreadyout == 1'b1)
    else $error("slave not ready");
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  trig_pulse_a: assert property ($rose(gpio_in[2]) |-> ##3 trigger_evt ##1 !trigger_evt)
    else $error("trigger pulse missing or too long");
  trig_cause_a: assert property (trigger_evt |-> $past(gpio_in[2], 3) && !$past(gpio_in[2], 4))
    else $error("trigger without a rise");
  run_start_a: assert property ($rose(gpio_in[0]) && !$rose(gpio_in[1]) |-> ##3 run_active)
    else $error("run did not start");
  run_cause_a: assert property ($rose(run_active) |-> $past(gpio_in[0], 3) && !$past(gpio_in[0], 4))
    else $error("run started without a rise");
  run_stop_a: assert property ($rose(gpio_in[1]) |-> ##3 !run_active)
    else $error("run did not stop");
  motor_on_a: assert property ($rose(gpio_in[3]) |-> ##3 motor_en)
    else $error("motor not enabled");
  cfg_first_a: assert property ($rose(gpio_in[4]) |-> ##3 cfg_sel == 2'h0)
    else $error("configuration one not selected");
  laser_run_a: assert property (laser_on |-> $past(run_active))
    else $error("laser on outside a run");
endmodule

bind ext_event_inputs event_inputs_monitor mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .gpio_in(gpio_in), .hreadyout(hreadyout),
  .hresp(hresp), .run_active(run_active), .trigger_evt(trigger_evt),
  .motor_en(motor_en), .cfg_sel(cfg_sel), .laser_on(laser_on));

`default_nettype wire

// ---- test/ext_event_inputs_tb.sv ----
// Self-checking bench for the event and encoder input block.
`default_nettype none
`include "ext_event_consts.vh"

module ext_event_inputs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  gpio_in = 8'h00;
  logic [2:0]  pa = 3'h0, pb = 3'h0, pz = 3'h0;
  logic        fault = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [1:0]  htrans = 2'h0, cfg_sel;
  logic [2:0]  hsize = 3'h0;
  logic [17:0] enc_line;
  logic        hreadyout, hresp, run_active, trigger_evt, motor_en, laser_on;
  logic [1:0]  q [3] = '{2'h0, 2'h0, 2'h0};
  int          bad_count = 0, tests_run = 0, trig_cnt = 0;

  // The clock toggles every half period of 5 ns.
  always #5 clk_sys = ~clk_sys;

  // Counting pulses rather than sampling once catches a double trigger.
  always @(posedge clk_sys) begin
    if (trigger_evt === 1'b1) begin
      trig_cnt <= trig_cnt + 1;
    end
  end

  enc_model far (.pa(pa), .pb(pb), .pz(pz), .fault(fault), .enc_line(enc_line));
  ext_event_inputs dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .gpio_in(gpio_in), .enc_line(enc_line),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .run_active(run_active), .trigger_evt(trigger_evt),
    .motor_en(motor_en), .cfg_sel(cfg_sel), .laser_on(laser_on));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Waits for ready under a bound; a slave that never answers ends the run.
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      report_and_stop;
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, ofs};
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    bus(1'b1, ofs, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  // A clean rise and fall, each held long enough to pass the synchroniser.
  task automatic pulse(input int i);
    gpio_in[i] <= 1'b1;
    ticks(6);
    gpio_in[i] <= 1'b0;
    ticks(6);
  endtask

  // Gray-code step: upward means A leads B.
  task automatic step(input int g, input logic up);
    q[g] = up ? q[g] + 2'h1 : q[g] - 2'h1;
    pa[g] <= q[g][1] ^ q[g][0];
    pb[g] <= q[g][1];
    ticks(6);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    ticks(3);
    rst_n <= 1'b1;
    ticks(10);
    rdc("ctrl", `OFS_CTRL, `CTRL_RST);
    rdc("win_lo", `OFS_WIN_LO, `WIN_LO_RST);
    rdc("win_hi", `OFS_WIN_HI, `WIN_HI_RST);
    for (int g = 0; g < 3; g++) rdc("shift", 8'(`OFS_SHIFT0 + 4*g), `SHIFT_RST);
    rdc("unmapped", 8'h80, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      case (i)
        0: chk("run", 1, run_active);
        1: chk("run", 0, run_active);
        2: chk("trig", 1, trig_cnt);
        3: chk("motor", 1, motor_en);
        default: chk("cfg", i - 4, cfg_sel);
      endcase
    end
    rdc("events", `OFS_EVENTS, 32'h0000_00FF);
    wr(`OFS_EVENTS, 32'h0000_00FF);
    rdc("events", `OFS_EVENTS, 32'h0000_0000);
    wr(`OFS_CTRL, 32'h0000_0002);
    ticks(2);
    chk("motor", 0, motor_en);
    gpio_in[0] <= 1'b1;
    ticks(6);
    pulse(1);
    chk("run", 0, run_active);
    gpio_in[0] <= 1'b0;
    ticks(6);
    chk("run", 0, run_active);
    for (int k = 0; k < 4; k++) step(0, 1'b1);
    rdc("pos0", `OFS_POS0, 32'h0000_0000);
    wr(`OFS_SHIFT0, 32'h0000_0005);
    wr(8'(`OFS_SHIFT0 + 4), 32'h0000_0003);
    wr(`OFS_CTRL, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      step(0, 1'b1);
      step(1, 1'b0);
    end
    rdc("pos0", `OFS_POS0, 32'h0000_0014);
    rdc("pos1", 8'(`OFS_POS0 + 4), 32'hFFFF_FFF4);
    rdc("pos2", 8'(`OFS_POS0 + 8), 32'h0000_0000);
    wr(`OFS_CTRL, 32'h0000_0005);
    pz[0] <= 1'b1;
    ticks(6);
    pz[0] <= 1'b0;
    rdc("pos0", `OFS_POS0, 32'h0000_0000);
    wr(`OFS_WIN_HI, 32'h0000_0064);
    wr(`OFS_POS0, 32'h0000_0032);
    pulse(0);
    chk("laser", 1, laser_on);
    wr(`OFS_POS0, 32'h0000_00C8);
    ticks(2);
    chk("laser", 0, laser_on);
    fault <= 1'b1;
    ticks(6);
    rdc("status", `OFS_STATUS, 32'h0004_000D);
    report_and_stop;
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
endmodule

`default_nettype wire
